// [include/display_scan_cfg.svh]
// offsets, field positions, reset values and timing counts of the display scan block
`ifndef DISPLAY_SCAN_CFG_SVH
`define DISPLAY_SCAN_CFG_SVH
// register indices; byte address is four times the index
`define REG_MODE0_IDX    13'h0000
`define REG_MODE1_IDX    13'h0001
`define REG_MODE2_IDX    13'h0002
`define RAM_FIRST_IDX    13'h0400
`define RAM_LAST_IDX     13'h046f
`define RAM_BYTES        112
`define BLOCK_BYTES      7
`define DRIVE_OUTS       53
`define DEDICATED_OUTS   24
`define SHARED_OUTS      29
`define BIDIR_FIRST      16
`define BIDIR_OUTS       13
`define MODE0_RESET      8'h10
`define MODE1_RESET      8'h01
`define MODE0_ON_BIT     7
`define MODE0_CNT_MSB    4
`define MODE1_BLANK_MSB  7
`define MODE1_BLANK_LSB  5
`define MODE1_PAT_MSB    3
`define MODE2_FLAG_BIT   7
`define MODE2_INSERT_BIT 6
`define MODE2_LEN_MSB    3
`define CLK_NS           4
`define UNIT_NS          1000
`define UNIT_CYC         ((`UNIT_NS + `CLK_NS - 1) / `CLK_NS)
`define SLOT_UNITS       16
`endif

// [include/display_scan_pkg.sv]
// types shared by the display scan block
package display_scan_pkg;
   typedef struct packed {
      logic [14:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } av_req_t;
   typedef struct packed {
      logic [52:0] level;
      logic [52:0] enable;
   } drive_pins_t;
   typedef enum logic [1:0] {
      SEQ_IDLE    = 2'b00,
      SEQ_DISPLAY = 2'b01,
      SEQ_KEYSCAN = 2'b11
   } seq_state_t;
endpackage : display_scan_pkg

// [verilog/scan_slot_timer.sv]
// slot length and symmetric blanking window for one display time slot
`timescale 1ns/1ps
`include "display_scan_cfg.svh"
module scan_slot_timer (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [3:0] cycle_len,
   input  wire logic [2:0] blank_w,
   output logic            slot_end,
   output logic            lit
);
   logic [7:0] div_cnt;
   logic       tick;
   logic [8:0] pos;
   logic [8:0] len_units;
   logic [8:0] blank_units;

   assign tick        = (div_cnt == 8'(`UNIT_CYC - 1));
   assign len_units   = 9'(({5'h00, cycle_len} + 9'h001) * 9'(`SLOT_UNITS));
   assign blank_units = 9'({6'h00, blank_w} * ({5'h00, cycle_len} + 9'h001));
   assign slot_end    = tick && (pos >= len_units - 9'h001);
   // same blank at both ends; max blank is 7/16 of a slot so a lit window always remains
   assign lit         = (pos >= blank_units) && (pos < len_units - blank_units);

   always_ff @(posedge clk) begin
      if (rst || !run || tick) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   // length change mid-slot ends the slot at the next unit tick rather than running past the end
   always_ff @(posedge clk) begin
      if (rst || !run || slot_end) begin
         pos <= 9'h000;
      end else if (tick) begin
         pos <= pos + 9'h001;
      end
   end
endmodule : scan_slot_timer

// [verilog/display_scan_ctrl.sv]
// display scan controller: mode registers, display memory, slot sequencer, drive outputs
//
// Operation
// - segment data is fetched from display memory by hardware, without the cpu
// - 53 drive outputs; 0-23 dedicated, 24-52 shared with ports 3 to 6
// - display enable cleared: shared outputs 24-52 are plain port pins
// - shared outputs not used for display stay ordinary port pins
// - brightness adjustable in eight steps via a field of mode register 1
// - mode register 0: enable bit and output count, resets to 10 hex
// - mode register 1: blanking width and pattern count, resets to 01 hex
// - mode register 2: key scan insert, cycle length, status; resets 00
// - outputs blanked equally at slot start and end by mode1 bits 7:5
// - display memory is 112 bytes at indices 0400 to 046f hex
// - display memory not used for display is ordinary cpu ram
// - key scan slot: drives low, outputs 24-52 show port 3-6 latches
// - with 53 outputs each slot uses one 7-byte block
// - blocks taken consecutively from the base, one per slot, up to 16
// - output 0 is bit 0 of the first byte, upward through output 52
// - key scan flag is 1 during the key scan slot, 0 in display slots
// - key scan flag is bit 7 of mode register 2 and read only
// - bit 6 of mode register 2 selects key scan slot insertion
// - a key scan interrupt request marks the key scan slot
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "display_scan_cfg.svh"
module display_scan_ctrl (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire display_scan_pkg::av_req_t av,
   output logic                       av_waitrequest,
   output logic [31:0]                av_readdata,
   input  wire logic [28:0]           port_latch,
   input  wire logic [12:0]           port_dir,
   output display_scan_pkg::drive_pins_t drive,
   output logic                       keyscan_irq
);
   logic [7:0]  display_mode_control_0;
   logic [7:0]  display_mode_control_1;
   logic        keyscan_slot_insert;
   logic [3:0]  display_cycle_length;
   logic        keyscan_active_flag;
   logic [7:0]  ram [0:`RAM_BYTES-1];
   logic        ack;
   logic        req;
   logic [12:0] idx;
   logic [6:0]  ram_off;
   logic [31:0] next_readdata;
   display_scan_pkg::seq_state_t state;
   display_scan_pkg::seq_state_t next_state;
   logic [3:0]  slot;
   logic [3:0]  next_slot;
   logic [4:0]  pattern_count;
   logic [5:0]  used_outs;
   logic [6:0]  block_base;
   logic [55:0] segments;
   logic        display_on;
   logic        slot_end;
   logic        lit;

   // true when the word index falls in display memory
   function automatic logic is_ram(input logic [12:0] i);
      is_ram = (i >= `RAM_FIRST_IDX) && (i <= `RAM_LAST_IDX);
   endfunction : is_ram

   // ---------------- bus slave ----------------
   assign req            = av.read || av.write;
   assign idx            = av.address[14:2];
   assign ram_off        = 7'(idx - `RAM_FIRST_IDX);
   // every access answers on its second cycle; read data is staged in the first
   assign av_waitrequest = req && !ack;

   always_ff @(posedge clk) begin
      if (rst) begin
         ack <= 1'b0;
      end else begin
         ack <= req && !ack;
      end
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      if (idx == `REG_MODE0_IDX) begin
         next_readdata[7:0] = display_mode_control_0;
      end else if (idx == `REG_MODE1_IDX) begin
         next_readdata[7:0] = display_mode_control_1;
      end else if (idx == `REG_MODE2_IDX) begin
         next_readdata[`MODE2_FLAG_BIT]        = keyscan_active_flag;
         next_readdata[`MODE2_INSERT_BIT]      = keyscan_slot_insert;
         next_readdata[`MODE2_LEN_MSB:0]       = display_cycle_length;
      end else if (is_ram(idx)) begin
         next_readdata[7:0] = ram[ram_off];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         av_readdata <= 32'h0000_0000;
      end else if (av.read && !ack) begin
         av_readdata <= next_readdata;
      end
   end

   // mode registers take effect on the edge that completes the write
   always_ff @(posedge clk) begin
      if (rst) begin
         display_mode_control_0 <= `MODE0_RESET;
         display_mode_control_1 <= `MODE1_RESET;
         keyscan_slot_insert    <= 1'b0;
         display_cycle_length   <= 4'h0;
      end else if (av.write && ack && av.byteenable[0]) begin
         if (idx == `REG_MODE0_IDX) begin
            display_mode_control_0 <= av.writedata[7:0];
         end
         if (idx == `REG_MODE1_IDX) begin
            display_mode_control_1 <= av.writedata[7:0];
         end
         // flag bit is not written: it only follows the sequencer
         if (idx == `REG_MODE2_IDX) begin
            keyscan_slot_insert  <= av.writedata[`MODE2_INSERT_BIT];
            display_cycle_length <= av.writedata[`MODE2_LEN_MSB:0];
         end
      end
   end

   // display memory is flip-flops; the scanner reads in parallel so it never adds a cpu wait cycle
   always_ff @(posedge clk) begin
      if (av.write && ack && av.byteenable[0] && is_ram(idx)) begin
         ram[ram_off] <= av.writedata[7:0];
      end
   end

   // ---------------- slot sequencer ----------------
   assign display_on    = display_mode_control_0[`MODE0_ON_BIT];
   assign pattern_count = {1'b0, display_mode_control_1[`MODE1_PAT_MSB:0]} + 5'h01;
   // output count field: 24 dedicated plus the field, limited to the 29 shared pins
   assign used_outs = (display_mode_control_0[`MODE0_CNT_MSB:0] > 5'(`SHARED_OUTS)) ?
                      6'(`DRIVE_OUTS) :
                      6'(`DEDICATED_OUTS) + {1'b0, display_mode_control_0[`MODE0_CNT_MSB:0]};
   assign block_base = 7'({3'h0, slot} * 7'(`BLOCK_BYTES));

   scan_slot_timer u_timer (
      .clk       (clk),
      .rst       (rst),
      .run       (state != display_scan_pkg::SEQ_IDLE),
      .cycle_len (display_cycle_length),
      .blank_w   (display_mode_control_1[`MODE1_BLANK_MSB:`MODE1_BLANK_LSB]),
      .slot_end  (slot_end),
      .lit       (lit)
   );

   always_comb begin
      next_state = state;
      next_slot  = slot;
      case (state)
         display_scan_pkg::SEQ_IDLE: begin
            if (display_on) begin
               next_state = display_scan_pkg::SEQ_DISPLAY;
               next_slot  = 4'h0;
            end
         end
         display_scan_pkg::SEQ_DISPLAY: begin
            if (slot_end) begin
               if ({1'b0, slot} + 5'h01 < pattern_count) begin
                  next_slot = slot + 4'h1;
               end else if (keyscan_slot_insert) begin
                  next_state = display_scan_pkg::SEQ_KEYSCAN;
               end else begin
                  next_slot = 4'h0;
               end
            end
         end
         display_scan_pkg::SEQ_KEYSCAN: begin
            if (slot_end) begin
               next_state = display_scan_pkg::SEQ_DISPLAY;
               next_slot  = 4'h0;
            end
         end
         default: begin
            next_state = display_scan_pkg::SEQ_IDLE;
            next_slot  = 4'h0;
         end
      endcase
      if (!display_on) begin
         next_state = display_scan_pkg::SEQ_IDLE;
         next_slot  = 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= display_scan_pkg::SEQ_IDLE;
         slot  <= 4'h0;
      end else begin
         state <= next_state;
         slot  <= next_slot;
      end
   end

   // flag is set on entry to the key scan slot and cleared on entry to a display slot
   always_ff @(posedge clk) begin
      if (rst) begin
         keyscan_active_flag <= 1'b0;
         keyscan_irq         <= 1'b0;
      end else begin
         keyscan_active_flag <= (next_state == display_scan_pkg::SEQ_KEYSCAN);
         keyscan_irq <= (next_state == display_scan_pkg::SEQ_KEYSCAN) &&
                        (state != display_scan_pkg::SEQ_KEYSCAN);
      end
   end

   // ---------------- drive outputs ----------------
   // direct read of the current block, byte 0 lowest: no cpu cycle is spent
   genvar b;
   generate
      for (b = 0; b < `BLOCK_BYTES; b++) begin : g_fetch
         assign segments[8*b+7:8*b] = ram[block_base + 7'(b)];
      end
   endgenerate

   genvar p;
   generate
      for (p = 0; p < `DRIVE_OUTS; p++) begin : g_out
         logic on_display;
         logic seg_on;
         assign on_display = display_on && (6'(p) < used_outs);
         assign seg_on     = (state == display_scan_pkg::SEQ_DISPLAY) && lit && segments[p];
         if (p < `DEDICATED_OUTS) begin : g_ded
            always_ff @(posedge clk) begin
               if (rst) begin
                  drive.level[p]  <= 1'b0;
                  drive.enable[p] <= 1'b0;
               end else begin
                  drive.level[p]  <= on_display && seg_on;
                  drive.enable[p] <= 1'b1;
               end
            end
         end else begin : g_shr
            logic port_oe;
            if (p - `DEDICATED_OUTS < `BIDIR_FIRST) begin : g_outonly
               assign port_oe = 1'b1;
            end else begin : g_bidir
               assign port_oe = port_dir[p - `DEDICATED_OUTS - `BIDIR_FIRST];
            end
            always_ff @(posedge clk) begin
               if (rst) begin
                  drive.level[p]  <= 1'b0;
                  drive.enable[p] <= 1'b0;
               end else if (on_display && state != display_scan_pkg::SEQ_KEYSCAN) begin
                  drive.level[p]  <= seg_on;
                  drive.enable[p] <= 1'b1;
               end else if (on_display) begin
                  drive.level[p]  <= port_latch[p - `DEDICATED_OUTS];
                  drive.enable[p] <= 1'b1;
               end else begin
                  drive.level[p]  <= port_latch[p - `DEDICATED_OUTS];
                  drive.enable[p] <= port_oe;
               end
            end
         end
      end
   endgenerate

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_flag_tracks_slot: assert property (
      keyscan_active_flag == (state == display_scan_pkg::SEQ_KEYSCAN))
      else $error("key scan flag disagrees with slot state");

   a_irq_marks_entry: assert property (
      keyscan_irq |-> state == display_scan_pkg::SEQ_KEYSCAN &&
                      $past(state) != display_scan_pkg::SEQ_KEYSCAN)
      else $error("key scan request outside key scan entry");

   a_keyscan_drive: assert property (
      state == display_scan_pkg::SEQ_KEYSCAN |=>
         drive.level[23:0] == 24'h000000 && drive.level[52:24] == $past(port_latch))
      else $error("key scan slot drive levels wrong");

   a_port_when_off: assert property (
      !display_on |=> drive.level[52:24] == $past(port_latch))
      else $error("shared pins not port pins while display off");

   a_blank_dark: assert property (
      !lit |=> drive.level[23:0] == 24'h000000)
      else $error("dedicated output lit inside blanking");

   a_flag_readback: assert property (
      av.read && !av_waitrequest && idx == `REG_MODE2_IDX |->
         av_readdata[7] == $past(keyscan_active_flag))
      else $error("flag read back wrong");

   a_mode_reset: assert property (
      $past(rst) |-> display_mode_control_0 == 8'h10 && display_mode_control_1 == 8'h01 &&
                     !keyscan_slot_insert && display_cycle_length == 4'h0)
      else $error("mode register reset value wrong");

   a_slot_wrap: assert property (
      state == display_scan_pkg::SEQ_DISPLAY && slot_end && display_on &&
      {1'b0, slot} + 5'h01 >= pattern_count && !keyscan_slot_insert |=>
         state == display_scan_pkg::SEQ_DISPLAY && slot == 4'h0)
      else $error("display cycle did not wrap to slot 0");

   a_keyscan_insert: assert property (
      state == display_scan_pkg::SEQ_DISPLAY && slot_end && display_on &&
      {1'b0, slot} + 5'h01 >= pattern_count && keyscan_slot_insert |=>
         state == display_scan_pkg::SEQ_KEYSCAN)
      else $error("key scan slot not inserted");

   a_ram_write: assert property (
      av.write && !av_waitrequest && av.byteenable[0] && is_ram(idx) |=>
         ram[$past(ram_off)] == $past(av.writedata[7:0]))
      else $error("display memory write lost");

   a_bus_answer: assert property (
      req && av_waitrequest |=> !av_waitrequest)
      else $error("bus answer later than one cycle");

   a_readdata_upper: assert property (
      av.read && !av_waitrequest |-> av_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");

   a_irq_one_cycle: assert property (
      keyscan_irq |=> !keyscan_irq)
      else $error("key scan request longer than one cycle");

   a_flag_entry: assert property (
      $rose(keyscan_active_flag) |->
         $past(state) == display_scan_pkg::SEQ_DISPLAY && $past(slot_end) &&
         $past(keyscan_slot_insert))
      else $error("key scan flag set outside the end of a display cycle");

   a_flag_clear: assert property (
      $fell(keyscan_active_flag) && !$past(rst) |-> $past(slot_end) || !$past(display_on))
      else $error("key scan flag cleared inside the key scan slot");

   a_dedicated_on: assert property (
      !$past(rst) |-> drive.enable[23:0] == 24'hffffff)
      else $error("dedicated output not driven");

   a_port_dir_off: assert property (
      !rst && !display_on |=> drive.enable[52:24] == {$past(port_dir), 16'hffff})
      else $error("shared pin enables wrong while display off");
endmodule : display_scan_ctrl

// [sim/panel_model.sv]
// display panel model: resolves the level seen on each drive pin
`timescale 1ns/1ps
module panel_model (
   input  wire display_scan_pkg::drive_pins_t drive,
   output logic [52:0]                        pins
);
   // a pin nobody drives falls to the pull-down, never holds its last value
   always_comb begin
      for (int k = 0; k < 53; k++) begin
         pins[k] = drive.enable[k] ? drive.level[k] : 1'b0;
      end
   end
endmodule : panel_model

// [sim/tb_display_scan_ctrl.sv]
// self-checking bench for the display scan controller
`timescale 1ns/1ps
module tb_display_scan_ctrl;
   typedef struct {logic [52:0] v; logic [52:0] m; string n;} note_t;
   logic                          clk;
   logic                          rst;
   display_scan_pkg::av_req_t     av;
   logic                          av_waitrequest;
   logic [31:0]                   av_readdata;
   logic [28:0]                   port_latch;
   logic [12:0]                   port_dir;
   display_scan_pkg::drive_pins_t drive;
   logic                          keyscan_irq;
   logic [52:0]                   pins;
   logic                          snap;
   logic                          snap_en;
   logic                          irq_look;
   note_t                         notes[$];
   int                            errors;
   int                            checked;
   logic [7:0]                    mem [0:13];

   display_scan_ctrl i_display_scan_ctrl (.clk(clk), .rst(rst), .av(av),
      .av_waitrequest(av_waitrequest), .av_readdata(av_readdata), .port_latch(port_latch),
      .port_dir(port_dir), .drive(drive), .keyscan_irq(keyscan_irq));
   panel_model i_panel_model (.drive(drive), .pins(pins));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic give_verdict();
      if (errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   task automatic check(input string nm, input logic [52:0] seen, input logic [52:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic take(input logic [52:0] seen);
      note_t n;
      if (notes.size() == 0) begin
         errors++;
         $display("MISMATCH unexpected result expected none seen %h", seen);
         return;
      end
      n = notes.pop_front();
      check(n.n, seen & n.m, n.v & n.m);
   endtask : take

   // results are matched to the oldest note as they appear at the ports
   always @(posedge clk) begin
      if (av.read && av_waitrequest === 1'b0) take({21'h000000, av_readdata});
      if (snap === 1'b1) take(snap_en ? drive.enable : pins);
      if (irq_look === 1'b1) take({52'h0, keyscan_irq});
   end

   // one idle edge first, so a release and a new request never share a time step
   task automatic bus(input logic [14:0] a, input logic wr, input logic [7:0] d,
                      input logic [3:0] be);
      @(posedge clk);
      av <= '{address: a, read: !wr, write: wr, writedata: {24'h000000, d}, byteenable: be};
      do @(posedge clk); while (av_waitrequest !== 1'b0);
      av <= '0;
   endtask : bus

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      bus(a, 1'b1, d, 4'hf);
   endtask : wr

   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      notes.push_back('{v: {45'h0, e}, m: 53'hffffffff, n: "readdata"});
      bus(a, 1'b0, 8'h00, 4'hf);
   endtask : rd

   task automatic probe(input string nm, input logic en, input logic [52:0] e,
                        input logic [52:0] m);
      notes.push_back('{v: e, m: m, n: nm});
      @(posedge clk);
      snap    <= 1'b1;
      snap_en <= en;
      @(posedge clk);
      snap    <= 1'b0;
   endtask : probe

   // the request must be gone one edge after it was seen
   task automatic wait_irq();
      do @(posedge clk); while (keyscan_irq !== 1'b1);
      notes.push_back('{v: 53'h0, m: '1, n: "keyscan_irq width"});
      irq_look <= 1'b1;
      @(posedge clk);
      irq_look <= 1'b0;
   endtask : wait_irq

   function automatic logic [52:0] blk(input int s);
      logic [52:0] v;
      for (int k = 0; k < 53; k++) v[k] = mem[7 * s + k / 8][k % 8];
      return v;
   endfunction : blk

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      give_verdict();
   end

   initial begin
      av = '0;
      rst = 1'b1;
      port_latch = '0;
      port_dir = '0;
      snap = 1'b0;
      snap_en = 1'b0;
      irq_look = 1'b0;
      errors = 0;
      checked = 0;
      void'($urandom(33871));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      port_latch <= 29'($urandom);
      port_dir <= 13'($urandom);
      rd(15'h0000, 8'h10);
      rd(15'h0004, 8'h01);
      rd(15'h0008, 8'h00);
      for (int i = 0; i < 14; i++) begin
         mem[i] = 8'($urandom);
         wr(15'h1000 + 15'(4 * i), mem[i]);
      end
      wr(15'h11bc, 8'h5a);
      rd(15'h11bc, 8'h5a);
      rd(15'h0100, 8'h00);
      bus(15'h0004, 1'b1, 8'hff, 4'h0);
      rd(15'h0004, 8'h01);
      for (int w = 0; w < 8; w++) begin
         wr(15'h0004, {3'(w), 5'h01});
         rd(15'h0004, {3'(w), 5'h01});
      end
      wr(15'h0004, 8'h01);
      wr(15'h0008, 8'hc0);
      rd(15'h0008, 8'h40);
      wr(15'h0000, 8'h9d);
      wait_irq();
      repeat (3) @(posedge clk);
      probe("keyscan pins", 1'b0, {port_latch, 24'h000000}, '1);
      rd(15'h0008, 8'hc0);
      repeat (5990) @(posedge clk);
      probe("slot 0 pins", 1'b0, blk(0), '1);
      rd(15'h0008, 8'h40);
      repeat (3990) @(posedge clk);
      probe("slot 1 pins", 1'b0, blk(1), '1);
      // blanking of one unit per side: dark at both ends of slot 0, lit between
      wr(15'h0004, 8'h21);
      wait_irq();
      repeat (4100) @(posedge clk);
      probe("blank head", 1'b0, 53'h0, '1);
      repeat (1900) @(posedge clk);
      probe("lit middle", 1'b0, blk(0), '1);
      repeat (1890) @(posedge clk);
      probe("blank tail", 1'b0, 53'h0, '1);
      wr(15'h0000, 8'h90);
      repeat (3) @(posedge clk);
      probe("enable 40 outs", 1'b1, {port_dir, 40'hff_ffff_ffff}, '1);
      probe("port pins 40", 1'b0, {port_latch[28:16] & port_dir, 40'h0},
            {13'h1fff, 40'h0});
      wr(15'h0000, 8'h1d);
      repeat (3) @(posedge clk);
      probe("enable off", 1'b1, {port_dir, 16'hffff, 24'h0}, {29'h1fffffff, 24'h0});
      probe("port pins off", 1'b0, {port_latch & {port_dir, 16'hffff}, 24'h0},
            {29'h1fffffff, 24'h0});
      // long slots, two patterns, no key scan slot: the cycle wraps straight to slot 0
      wr(15'h0008, 8'h01);
      wr(15'h0004, 8'h01);
      wr(15'h0000, 8'h9d);
      repeat (6000) @(posedge clk);
      probe("long slot 0", 1'b0, blk(0), '1);
      rd(15'h0008, 8'h01);
      repeat (10100) @(posedge clk);
      probe("wrap no keyscan", 1'b0, blk(0), '1);
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule : tb_display_scan_ctrl
